// File: hdl/iemb_top.sv
// Interrupt event mask bank with monitor capture, APB slave and interrupt
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "iemb_params.svh"
`default_nettype none

module iemb_top #(
    parameter int ADDR_W = 16
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    input  wire iemb_pkg::iemb_bank_type event_pulse,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq,
    output var iemb_pkg::iemb_bank_type mask_bits,
    output var iemb_pkg::iemb_bank_type monitor_bits
);
    import iemb_pkg::*;

    localparam int NREG = `IEMB_NUM_REGS;
    localparam int IW   = `IEMB_INDEX_W;

    // ****************************************
    // Writable bits of each register
    // ****************************************

    // Reserved positions are cleared out of every path
    localparam iemb_flat_type VALID = {
        `IEMB_VALID_ANALOG,
        `IEMB_VALID_LOOP,
        `IEMB_VALID_LOOP,
        `IEMB_VALID_ANALOG,
        `IEMB_VALID_LOOP,
        `IEMB_VALID_LOOP,
        `IEMB_VALID_REF,
        `IEMB_VALID_REF,
        `IEMB_VALID_SYS
    };

    localparam logic [IW-1:0] MASK_BASE = `IEMB_MASK_BASE_IDX;
    localparam logic [IW-1:0] MON_BASE  = `IEMB_MONITOR_BASE_IDX;

    // ****************************************
    // Storage
    // ****************************************
    iemb_flat_type  mask_r;
    iemb_flat_type  mon_r;
    iemb_flat_type  mon_nxt;
    iemb_flat_type  events;
    iemb_flat_type  capture;
    iemb_flat_type  clear;
    logic [31:0]    prdata_r;
    logic           pready_r;
    logic           pslverr_r;
    logic           irq_r;

    // ****************************************
    // APB decode
    // ****************************************
    logic              access;
    logic              first_access;
    logic              done;
    logic              aligned;
    logic [IW-1:0]     index;
    logic [NREG-1:0]   hit_mask;
    logic [NREG-1:0]   hit_mon;
    logic              mapped;
    logic [7:0]        rd_byte;

    assign events = iemb_flat_type'(event_pulse);

    // Phase tracking of the current transfer
    assign access       = psel & penable;
    assign first_access = access & ~pready_r;
    assign done         = access & pready_r;

    // Word index and alignment check
    assign index   = paddr[`IEMB_INDEX_LSB +: IW];
    assign aligned = (paddr[1:0] == 2'b00)
                   && (paddr[ADDR_W-1:`IEMB_INDEX_LSB+IW] == '0);

    // Register hits and read mux
    always_comb begin
        hit_mask = '0;
        hit_mon  = '0;
        rd_byte  = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (aligned && (index == MASK_BASE + IW'(i))) begin
                hit_mask[i] = 1'b1;
                rd_byte     = mask_r[i] & VALID[i];
            end
            if (aligned && (index == MON_BASE + IW'(i))) begin
                hit_mon[i] = 1'b1;
                rd_byte    = mon_r[i];
            end
        end
    end

    assign mapped = |{hit_mask, hit_mon};

    // ****************************************
    // APB answer: one wait cycle, then ready
    // ****************************************

    // Ready rises in the second access cycle and drops after completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= first_access;
        end
    end

    // Read data is captured while ready is low, so it stands with ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (first_access && !pwrite) begin
            prdata_r <= {24'h00_0000, rd_byte};
        end else if (done) begin
            prdata_r <= 32'h0000_0000;
        end
    end

    // Unmapped or misaligned addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= first_access & ~mapped;
        end
    end

    // ****************************************
    // Mask registers
    // ****************************************

    // Writes land on the completing edge; low byte lane only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= {NREG{`IEMB_MASK_RESET}};
        end else begin
            for (int i = 0; i < NREG; i++) begin
                if (done && pwrite && pstrb[0] && hit_mask[i]) begin
                    mask_r[i] <= pwdata[7:0] & VALID[i];
                end
            end
        end
    end

    // ****************************************
    // Monitor capture
    // ****************************************

    // Only live events under a set mask bit reach the monitor
    assign capture = events & mask_r & VALID;

    // Write one to clear, lane zero only
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            if (done && pwrite && pstrb[0] && hit_mon[i]) begin
                clear[i] = pwdata[7:0];
            end else begin
                clear[i] = 8'h00;
            end
        end
    end

    // Set wins over a clear in the same cycle
    assign mon_nxt = (mon_r & ~clear) | capture;

    // Sticky monitor bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_r <= '0;
        end else begin
            mon_r <= mon_nxt;
        end
    end

    // ****************************************
    // Interrupt output
    // ****************************************

    // Level output while any unmasked monitor bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(mon_r & mask_r);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign irq          = irq_r;
    assign mask_bits    = iemb_bank_type'(mask_r);
    assign monitor_bits = iemb_bank_type'(mon_r);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Transfer phases
    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence apb_wait_s;
        psel && penable && !pready_r;
    endsequence

    sequence apb_write_done_s;
        psel && penable && pready_r && pwrite && pstrb[0];
    endsequence

    // A transfer waits exactly one cycle for ready
    apb_answer_a: assert property (apb_setup_s ##1 apb_wait_s |=> pready_r)
        else $error("ready did not follow the wait cycle");

    // Masks come out of reset cleared
    mask_reset_a: assert property (disable iff (1'b0)
        $rose(presetn) |-> (mask_r == '0) && (mon_r == '0))
        else $error("mask or monitor not zero after reset");

    // Reserved positions never hold a one
    reserved_zero_a: assert property (
        ((mask_r & ~VALID) == '0) && ((mon_r & ~VALID) == '0))
        else $error("reserved bit set");

    // Each written register takes its byte masked by the valid bits
    generate
        for (genvar g = 0; g < NREG; g++) begin : g_chk
            mask_write_a: assert property (
                apb_write_done_s ##0 hit_mask[g]
                |=> mask_r[g] == ($past(pwdata[7:0]) & VALID[g]))
                else $error("mask write not stored");
        end
    endgenerate

    // An event under a set mask is recorded on the next edge
    masked_capture_a: assert property (
        (capture != '0) |=> ((mon_r & $past(capture)) == $past(capture)))
        else $error("enabled event not captured");

    // A monitor bit only rises from a captured event
    no_blind_set_a: assert property (
        ##1 ((mon_r & ~$past(mon_r) & ~$past(capture)) == '0))
        else $error("monitor bit set without enabled event");

    // Watchdog expiry shows up only when enabled
    watchdog_gate_a: assert property (
        events[0][`IEMB_WATCHDOG_BIT] && !mask_r[0][`IEMB_WATCHDOG_BIT]
        && !mon_r[0][`IEMB_WATCHDOG_BIT]
        |=> !mon_r[0][`IEMB_WATCHDOG_BIT])
        else $error("masked watchdog event recorded");

    // Clock unlock event reaches its monitor bit
    sys_unlock_a: assert property (
        events[0][`IEMB_SYS_UNLOCKED_BIT] && mask_r[0][`IEMB_SYS_UNLOCKED_BIT]
        |=> mon_r[0][`IEMB_SYS_UNLOCKED_BIT])
        else $error("unlock event lost");

    // Loop one holdover rides in the eighth register
    loop1_hold_a: assert property (
        events[7][`IEMB_LOOP_HOLDOVER_BIT] && mask_r[7][`IEMB_LOOP_HOLDOVER_BIT]
        |=> mon_r[7][`IEMB_LOOP_HOLDOVER_BIT])
        else $error("loop one holdover event lost");

    // Bad address answers with an error together with ready
    apb_error_a: assert property (
        apb_wait_s ##0 !mapped |=> pready_r && pslverr_r)
        else $error("unmapped access without error");

    // Interrupt follows unmasked monitor bits by one cycle
    irq_level_a: assert property (
        ((mon_r & mask_r) != '0) |=> irq_r)
        else $error("interrupt not raised");

    // Interrupt drops once nothing unmasked is pending
    irq_quiet_a: assert property (
        ((mon_r & mask_r) == '0) |=> !irq_r)
        else $error("interrupt raised without pending event");

    // Wait cycle of a read transfer
    sequence apb_read_wait_s;
        psel && penable && !pready_r && !pwrite;
    endsequence

    // Read data stands with ready and carries the selected byte
    read_data_a: assert property (
        apb_read_wait_s |=> pready_r && (prdata_r == {24'h00_0000, $past(rd_byte)}))
        else $error("read data wrong");

    // Read data is zero whenever no answer stands
    prdata_idle_a: assert property (
        !pready_r |-> (prdata_r == 32'h0000_0000))
        else $error("read data outside an answer");

    // Error is only ever shown together with ready
    error_ready_a: assert property (
        pslverr_r |-> pready_r)
        else $error("error without ready");

    // Masks change only through a completed write
    mask_hold_a: assert property (
        !(done && pwrite && pstrb[0] && (hit_mask != '0)) |=> $stable(mask_r))
        else $error("mask changed without a write");

    // A clear and an event on one bit in one cycle leave it set
    set_wins_a: assert property (
        ((capture & clear) != '0)
        |=> ((mon_r & $past(capture) & $past(clear)) == ($past(capture) & $past(clear))))
        else $error("clear beat a same-cycle event");

    // Writing a one clears a bit with no event behind it
    w1c_clear_a: assert property (
        ((clear & ~capture & mon_r) != '0)
        |=> ((mon_r & $past(clear) & ~$past(capture)) == '0))
        else $error("monitor bit not cleared");

    // Reference A fault is not recorded while its mask is clear
    ref_gate_a: assert property (
        events[1][`IEMB_REF_LO_LSB] && !mask_r[1][`IEMB_REF_LO_LSB]
        && !mon_r[1][`IEMB_REF_LO_LSB]
        |=> !mon_r[1][`IEMB_REF_LO_LSB])
        else $error("masked reference event recorded");

    // Stability event reaches its monitor bit
    sys_stable_a: assert property (
        events[0][`IEMB_SYS_STABLE_BIT] && mask_r[0][`IEMB_SYS_STABLE_BIT]
        |=> mon_r[0][`IEMB_SYS_STABLE_BIT])
        else $error("stability event lost");

    // Memory fault event reaches its monitor bit
    mem_fault_a: assert property (
        events[0][`IEMB_MEM_FAULT_BIT] && mask_r[0][`IEMB_MEM_FAULT_BIT]
        |=> mon_r[0][`IEMB_MEM_FAULT_BIT])
        else $error("memory fault event lost");

    // Loop zero reference switch reaches its monitor bit
    loop0_switch_a: assert property (
        events[4][`IEMB_LOOP_SWITCH_BIT] && mask_r[4][`IEMB_LOOP_SWITCH_BIT]
        |=> mon_r[4][`IEMB_LOOP_SWITCH_BIT])
        else $error("loop zero switch event lost");

    // Sync event of the second analog group reaches its monitor bit
    analog1_sync_a: assert property (
        events[8][`IEMB_ANALOG_SYNC_BIT] && mask_r[8][`IEMB_ANALOG_SYNC_BIT]
        |=> mon_r[8][`IEMB_ANALOG_SYNC_BIT])
        else $error("sync event lost");

endmodule : iemb_top

`default_nettype wire

// File: include/iemb_params.svh
// Constants for the interrupt event mask bank: offsets, fields and reset values
`ifndef IEMB_PARAMS_SVH
`define IEMB_PARAMS_SVH

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define IEMB_SYSTEM_CLOCK_PLL_WD_MEM_MASK_IDX 12'h010A
`define IEMB_REF_AB_MASK_IDX        12'h010B
`define IEMB_REF_CD_MASK_IDX        12'h010C
`define IEMB_LOOP0_LOCK_MASK_IDX    12'h010D
`define IEMB_LOOP0_STATE_MASK_IDX   12'h010E
`define IEMB_ANALOG0_SYNC_MASK_IDX  12'h010F
`define IEMB_LOOP1_LOCK_MASK_IDX    12'h0110
`define IEMB_LOOP1_STATE_MASK_IDX   12'h0111
`define IEMB_ANALOG1_SYNC_MASK_IDX  12'h0112
`define IEMB_MASK_BASE_IDX          12'h010A
`define IEMB_MONITOR_BASE_IDX       12'h0D08
`define IEMB_NUM_REGS               9
`define IEMB_INDEX_LSB              2
`define IEMB_INDEX_W                12

// ****************************************
// Reset value and writable bits of each register
// ****************************************
`define IEMB_MASK_RESET             8'h00
`define IEMB_VALID_SYS              8'h7B
`define IEMB_VALID_REF              8'h77
`define IEMB_VALID_LOOP             8'hFF
`define IEMB_VALID_ANALOG           8'h1F

// ****************************************
// Field positions
// ****************************************
`define IEMB_SYS_UNLOCKED_BIT       6
`define IEMB_SYS_STABLE_BIT         5
`define IEMB_SYS_LOCKED_BIT         4
`define IEMB_WATCHDOG_BIT           3
`define IEMB_MEM_FAULT_BIT          1
`define IEMB_MEM_DONE_BIT           0
`define IEMB_REF_LO_LSB             0
`define IEMB_REF_HI_LSB             4
`define IEMB_LOOP_SWITCH_BIT        7
`define IEMB_LOOP_FREERUN_BIT       6
`define IEMB_LOOP_HOLDOVER_BIT      5
`define IEMB_LOOP_HISTORY_BIT       4
`define IEMB_ANALOG_SYNC_BIT        4

`endif

// File: include/iemb_pkg.sv
// Types shared by the interrupt event mask bank
package iemb_pkg;

    // One byte per register, index 0 in the low byte
    typedef struct packed {
        logic [7:0] analog1_sync;
        logic [7:0] loop1_state;
        logic [7:0] loop1_lock;
        logic [7:0] analog0_sync;
        logic [7:0] loop0_state;
        logic [7:0] loop0_lock;
        logic [7:0] ref_cd;
        logic [7:0] ref_ab;
        logic [7:0] system_clock_pll_wd_mem;
    } iemb_bank_type;

    // Flat view of the bank, register i in byte i
    typedef logic [8:0][7:0] iemb_flat_type;

endpackage : iemb_pkg

// File: bench/tb.sv
// Self-checking testbench for the interrupt event mask bank
`timescale 1ns/1ps
`include "iemb_params.svh"
`default_nettype none

module tb;
    import iemb_pkg::*;

    typedef struct packed {
        logic [11:0] idx;
        logic [7:0]  wd;
        logic [7:0]  exp;
    } iemb_row_type;

    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [15:0]   paddr;
    logic [31:0]   pwdata;
    logic [3:0]    pstrb;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    iemb_bank_type event_pulse;
    iemb_bank_type mask_bits;
    iemb_bank_type monitor_bits;
    iemb_flat_type mask_flat;
    iemb_flat_type mon_flat;
    iemb_flat_type ev;
    logic [7:0]    valid [9];
    iemb_row_type  rows [9];
    logic [31:0]   rd;
    logic          err;
    int            fail_count;
    int            compares;
    int            cycles;

    assign mask_flat = mask_bits;
    assign mon_flat  = monitor_bits;

    iemb_top iemb_top_inst (
        .pclk         (pclk),
        .presetn      (presetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .pstrb        (pstrb),
        .event_pulse  (event_pulse),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .irq          (irq),
        .mask_bits    (mask_bits),
        .monitor_bits (monitor_bits)
    );

    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    // Free running 250 MHz clock
    always #2 pclk = ~pclk;

    // Cut a hang short
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            final_report();
        end
    end

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                       input logic [3:0] st, output logic [31:0] rdat, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h00_0000, wd};
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        e    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);    // Idle edge keeps the next setup off this time step
    endtask : apb

    // Compare and count
    task automatic check(input logic [71:0] got, input logic [71:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // Pulse one event pattern for one edge, then let monitor and irq settle
    task automatic pulse(input iemb_flat_type p);
        event_pulse <= p;
        @(posedge pclk);
        event_pulse <= '0;
        repeat (2) @(posedge pclk);
    endtask : pulse

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        event_pulse = '0;
        fail_count = 0;
        compares = 0;
        cycles = 0;
        valid = '{`IEMB_VALID_SYS, `IEMB_VALID_REF, `IEMB_VALID_REF, `IEMB_VALID_LOOP,
                  `IEMB_VALID_LOOP, `IEMB_VALID_ANALOG, `IEMB_VALID_LOOP, `IEMB_VALID_LOOP,
                  `IEMB_VALID_ANALOG};
        for (int i = 0; i < 9; i++) begin
            rows[i] = '{`IEMB_MASK_BASE_IDX + 12'(i), 8'hFF, valid[i]};
        end
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(mask_flat, '0);
        pulse('1);
        check(mon_flat, '0);
        // Register table rows: reset value, write all ones, read back
        foreach (rows[i]) begin
            apb(1'b0, rows[i].idx, 8'h00, 4'h1, rd, err);
            check(rd, 0);
            apb(1'b1, rows[i].idx, rows[i].wd, 4'h1, rd, err);
            check(err, 0);
            apb(1'b0, rows[i].idx, 8'h00, 4'h1, rd, err);
            check(rd, {24'h00_0000, rows[i].exp});
        end
        @(posedge pclk);
        foreach (rows[i]) begin
            check(mask_flat[i], rows[i].exp);
        end
        check(mon_flat, '0);
        // Every bit position alone, then cleared by writing one
        for (int i = 0; i < 9; i++) begin
            for (int j = 0; j < 8; j++) begin
                ev = '0;
                ev[i][j] = 1'b1;
                pulse(ev);
                ev[i] = ev[i] & valid[i];
                check(mon_flat, ev);
                check(irq, |ev);
                apb(1'b0, `IEMB_MONITOR_BASE_IDX + 12'(i), 8'h00, 4'h1, rd, err);
                check(rd, {24'h00_0000, ev[i]});
                apb(1'b1, `IEMB_MONITOR_BASE_IDX + 12'(i), 8'(8'h01 << j), 4'h1, rd, err);
                @(posedge pclk);
                check(mon_flat, '0);
                check(irq, 0);
            end
        end
        // Partial masks gate bit by bit; clearing the mask drops irq only
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, rows[i].idx, 8'h55, 4'h1, rd, err);
            ev = '0;
            ev[i] = 8'hFF;
            pulse(ev);
            ev[i] = 8'h55 & valid[i];
            check(mon_flat, ev);
            apb(1'b1, rows[i].idx, 8'h00, 4'h1, rd, err);
            repeat (2) @(posedge pclk);
            check(irq, 0);
            check(mon_flat, ev);
            apb(1'b1, `IEMB_MONITOR_BASE_IDX + 12'(i), 8'hFF, 4'h1, rd, err);
        end
        // Unmapped place and write with the byte strobe off
        apb(1'b1, 12'h0200, 8'hFF, 4'h1, rd, err);
        check(err, 1);
        apb(1'b0, 12'h0200, 8'h00, 4'h1, rd, err);
        check({err, rd}, 33'h1_0000_0000);
        apb(1'b1, rows[0].idx, 8'hFF, 4'h0, rd, err);
        @(posedge pclk);
        check(mask_flat[0], 0);
        // Event at the completing edge of its own clear keeps the bit set
        apb(1'b1, rows[0].idx, 8'hFF, 4'h1, rd, err);
        ev = '0;
        ev[0][0] = 1'b1;
        pulse(ev);
        fork
            apb(1'b1, `IEMB_MONITOR_BASE_IDX, 8'h01, 4'h1, rd, err);
            begin
                do begin
                    @(posedge pclk);
                end while (!(psel && penable && !pready));
                event_pulse <= ev;
                @(posedge pclk);
                event_pulse <= '0;
            end
        join
        check(mon_flat, ev);
        // Reset in mid-run clears the masks
        apb(1'b1, rows[3].idx, 8'hFF, 4'h1, rd, err);
        check(mask_flat[3], 8'hFF);
        presetn <= 1'b0;
        @(posedge pclk);
        check(mask_flat, '0);
        check(mon_flat, '0);
        presetn <= 1'b1;
        @(posedge pclk);
        final_report();
    end
endmodule : tb

`default_nettype wire
